// >>> common/tcs_regs.vh
/*
 * Register offsets, field positions, reset values and timing counts for the trace
 * capture stop and flush control block.
 * Assumes it is included by bare name from the design files of this block.
 */
`ifndef TCS_REGS_VH
`define TCS_REGS_VH

// ****************************************************************
// Register offsets (word addresses on the plain register port)
// ****************************************************************
`define TCS_ADDR_W        4
`define TCS_OFS_CTRL      4'h0
`define TCS_OFS_FORMATTER_FLUSH_CONTROL      4'h1
`define TCS_OFS_STATUS    4'h2
`define TCS_OFS_TRGCNT    4'h3
`define TCS_OFS_WRPTR     4'h4

// ****************************************************************
// Control register fields
// ****************************************************************
`define TCS_CTRL_CAPEN    0

// ****************************************************************
// Formatter and flush control fields
// ****************************************************************
`define TCS_FF_FMTEN      0
`define TCS_FF_CONTEN     1
`define TCS_FF_FLUSHIN_EN 4
`define TCS_FF_FLUSH_ON_TRIGGER_EVENT    5
`define TCS_FF_MANFLUSH   6
`define TCS_FF_MARKTRIN   8
`define TCS_FF_MARKEVT    9
`define TCS_FF_MARKFL     10
`define TCS_FF_HALTFL     12
`define TCS_FF_HALTTRIG   13
`define TCS_FF_W          14
`define TCS_FF_RESET      14'h0000

// ****************************************************************
// Status register fields
// ****************************************************************
`define TCS_ST_FLUSHBUSY  0
`define TCS_ST_HALTED     1
`define TCS_ST_TRIGGERED  2
`define TCS_ST_ACQDONE    3
`define TCS_ST_FULL       4

// ****************************************************************
// Formatter modes and post-amble figures
// ****************************************************************
`define TCS_MODE_BYPASS   2'b00
`define TCS_MODE_NORMAL   2'b01
`define TCS_MODE_CONT     2'b11
`define TCS_BYP_END_BYTE  8'h01
`define TCS_PAD_BYTE      8'h00
`define TCS_BYP_MAX_WORDS 2
`define TCS_FRAME_WORDS   4
`define TCS_WORST_EXTRA   7

`endif

// >>> hdl/tcs_flush_slot.v
/*
 * One pending slot of a flush source.
 * Assumes req is a level from the source and take is a one-cycle grant pulse.
 */
`timescale 1ns/10ps

module tcs_flush_slot (
  input  wire clk,
  input  wire sys_rst,
  input  wire enable,
  input  wire req,
  input  wire take,
  input  wire done,
  output reg  pending
);

  reg req_q;
  reg served;

  // A source that drops and raises its request while served or pended adds nothing.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_q   <= 1'b0;
      pending <= 1'b0;
      served  <= 1'b0;
    end else begin
      req_q <= req;
      if (take) begin
        served <= 1'b1;
      end else if (done) begin
        served <= 1'b0;
      end
      if (enable && req && !req_q && !served && !take) begin
        pending <= 1'b1; // see RULE7 see RULE8
      end else if (take) begin
        pending <= 1'b0;
      end
    end
  end

endmodule

// >>> hdl/tcs_trace_ram.v
/*
 * Trace word memory with a memory-test port that takes exclusive access.
 * Assumes all accesses are whole 32-bit words.
 */
`timescale 1ns/10ps

module tcs_trace_ram #(
  parameter AW = 8
) (
  input  wire          clk,
  input  wire          test_sel,
  input  wire [AW-1:0] test_addr,
  input  wire          test_cs,
  input  wire          test_we,
  input  wire [31:0]   test_din,
  output reg  [31:0]   test_dout,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [31:0]   wr_data
);

  reg [31:0] mem [0:(1<<AW)-1];

  // Whole-word storage only, so no byte lanes exist.
  always @(posedge clk) begin
    if (test_sel) begin
      if (test_cs && test_we) begin
        mem[test_addr] <= test_din; // see RULE16 see RULE17
      end
      if (test_cs) begin
        test_dout <= mem[test_addr];
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data; // see RULE16
    end
  end

endmodule

// >>> hdl/tcs_capture_ctrl.v
/*
 * Trace capture stop and flush controller: decides when capture stops, arbitrates
 * three flush sources, marks triggers in continuous-mode trace and writes trace words.
 * Assumes trace beats arrive as 32-bit words with a valid strobe, one clock,
 * and a simple register port with read data one cycle after the read strobe.
 */
`timescale 1ns/10ps
`include "tcs_regs.vh"

// Overview of operation
// RULE1: Stop capture on enable clear, trigger with counter zero, or flush done with halt.
// RULE2: Set the halted flag whenever capture has stopped.
// RULE3: Halt-on-trigger and halt-on-flush together; halt-on-trigger drops flushed data.
// RULE4: After stop, keep accepting trace beats and discard them.
// RULE5: Input, trigger and manual flush sources may be enabled together.
// RULE6: Finish the running flush before starting the next one.
// RULE7: Each flush source holds at most one pending request.
// RULE8: Re-raised request during service or pending makes no extra flush.
// RULE9: Trigger event is counter reaching zero, or trigger input while counter zero.
// RULE10: All three trigger-mark enables may act together, giving multiple marks.
// RULE11: Trigger counter is words still to write after the trigger input.
// RULE12: After a flush in normal or continuous mode emit one empty frame; the code emits it only when capture stops.
// RULE13: In bypass mode the post-amble adds at most two words.
// RULE14: Trigger marks go into trace only in continuous mode.
// RULE15: Flush-on-trigger raises a flush request on each trigger event.
// RULE16: All trace memory accesses are full 32-bit words.
// RULE17: Memory-test select gives the test port sole access to trace memory.
// RULE18: Mode bits: both clear bypass, enable alone normal, both set continuous.
// RULE19: Bypass stop writes byte 0x01 then zero bytes to a word boundary.
// RULE20: Acquisition-done output when capture complete and trigger counter zero.
// RULE21: Memory-full output when write pointer wraps to address zero.
// RULE22: Counter decrements per word written after a trigger, holding at zero.
// RULE23: Flush completes on upstream acknowledge; request held until then.
module tcs_capture_ctrl #(
  parameter AW = 8
) (
  input  wire                  clk,
  input  wire                  sys_rst,
  input  wire [`TCS_ADDR_W-1:0] reg_addr,
  input  wire [31:0]           reg_wdata,
  input  wire                  reg_wr,
  input  wire                  reg_rd,
  output reg  [31:0]           reg_rdata,
  input  wire                  beat_valid,
  input  wire [31:0]           beat_data,
  input  wire [1:0]            beat_bytes,
  output reg                   beat_ready,
  output reg                   flush_req,
  input  wire                  flush_ack,
  input  wire                  trig_in,
  input  wire                  flush_in,
  output reg                   acq_done,
  output reg                   mem_full,
  output reg                   trig_mark,
  input  wire                  test_sel,
  input  wire [AW-1:0]         test_addr,
  input  wire                  test_cs,
  input  wire                  test_we,
  input  wire [31:0]           test_din,
  output wire [31:0]           test_dout
);

  // ****************************************************************
  // State
  // ****************************************************************
  localparam ST_RUN   = 2'd0;
  localparam ST_PAD   = 2'd1;
  localparam ST_STOP  = 2'd2;
  // A formatted stop closes with one whole empty frame.
  localparam integer FRAME_WORDS = `TCS_FRAME_WORDS;

  reg                  capture_enable_bit;
  reg [`TCS_FF_W-1:0]  formatter_flush_control;
  reg [31:0]           trig_count;
  reg                  triggered;
  reg                  formatter_halted_flag;
  reg [1:0]            state;
  reg [AW-1:0]         wr_ptr;
  reg [31:0]           wr_data;
  reg                  wr_en;
  reg [3:0]            post_words;
  reg                  flush_busy;
  reg [1:0]            flush_src;
  reg                  trig_in_q;
  reg                  manual_pulse;
  reg                  halting;
  reg                  drop_flush;
  reg                  trig_armed;

  wire formatting_enable            = formatter_flush_control[`TCS_FF_FMTEN];
  wire continuous_formatting_enable = formatter_flush_control[`TCS_FF_CONTEN];
  wire halt_on_trigger              = formatter_flush_control[`TCS_FF_HALTTRIG];
  wire halt_on_flush                = formatter_flush_control[`TCS_FF_HALTFL];
  wire flush_on_trigger_event       = formatter_flush_control[`TCS_FF_FLUSH_ON_TRIGGER_EVENT];
  wire mark_on_trigger_event        = formatter_flush_control[`TCS_FF_MARKEVT];
  wire mark_on_flush                = formatter_flush_control[`TCS_FF_MARKFL];
  wire mark_on_trig_in              = formatter_flush_control[`TCS_FF_MARKTRIN];

  wire [1:0] mode = {continuous_formatting_enable, formatting_enable}; // see RULE18
  wire bypass = (mode == `TCS_MODE_BYPASS);
  wire contin = (mode == `TCS_MODE_CONT);

  wire running  = (state == ST_RUN) && capture_enable_bit && !test_sel;
  wire take_beat = running && beat_valid;
  wire count_word = take_beat && trig_armed && (trig_count != 32'h0000_0000);

  // The counter reaches zero on this word, or was already zero with the input high.
  wire trig_event = (count_word && trig_count == 32'h0000_0001) ||
                    (running && !triggered && trig_count == 32'h0000_0000 &&
                     trig_in); // see RULE9
  wire trig_in_rise = trig_in && !trig_in_q;

  // ****************************************************************
  // Flush sources and arbitration
  // ****************************************************************
  wire [2:0] pend;
  wire [2:0] take;
  wire       flush_done = flush_busy && flush_ack; // see RULE23
  wire [2:0] src_req = {manual_pulse, trig_event, flush_in};
  wire [2:0] src_en  = {1'b1, flush_on_trigger_event, formatter_flush_control[`TCS_FF_FLUSHIN_EN]};

  // Fixed priority; a new flush only starts once the running one is done.
  assign take[0] = !flush_busy && pend[0]; // see RULE6
  assign take[1] = !flush_busy && pend[1] && !pend[0];
  assign take[2] = !flush_busy && pend[2] && !pend[1] && !pend[0];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_slot
      tcs_flush_slot u_slot (
        .clk     (clk),
        .sys_rst (sys_rst),
        .enable  (src_en[gi]), // see RULE5 see RULE15
        .req     (src_req[gi]),
        .take    (take[gi]),
        .done    (flush_done && flush_src == gi),
        .pending (pend[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Register port
  // ****************************************************************
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      capture_enable_bit <= 1'b0;
      formatter_flush_control               <= `TCS_FF_RESET;
      manual_pulse       <= 1'b0;
      reg_rdata          <= 32'h0000_0000;
    end else begin
      manual_pulse <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `TCS_OFS_CTRL: capture_enable_bit <= reg_wdata[`TCS_CTRL_CAPEN];
          `TCS_OFS_FORMATTER_FLUSH_CONTROL: begin
            formatter_flush_control         <= reg_wdata[`TCS_FF_W-1:0];
            manual_pulse <= reg_wdata[`TCS_FF_MANFLUSH];
          end
          default: ;
        endcase
      end
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `TCS_OFS_CTRL:   reg_rdata <= {31'h0, capture_enable_bit};
          `TCS_OFS_FORMATTER_FLUSH_CONTROL:   reg_rdata <= {{(32-`TCS_FF_W){1'b0}}, formatter_flush_control};
          `TCS_OFS_STATUS: reg_rdata <= {27'h0, mem_full, acq_done, triggered,
                                         formatter_halted_flag, flush_busy};
          `TCS_OFS_TRGCNT: reg_rdata <= trig_count;
          `TCS_OFS_WRPTR:  reg_rdata <= {{(32-AW){1'b0}}, wr_ptr};
          default:         reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Capture, stop and post-amble
  // ****************************************************************
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state                 <= ST_RUN;
      trig_count            <= 32'h0000_0000;
      triggered             <= 1'b0;
      formatter_halted_flag <= 1'b0;
      wr_ptr                <= {AW{1'b0}};
      wr_data               <= 32'h0000_0000;
      wr_en                 <= 1'b0;
      post_words            <= 4'h0;
      flush_busy            <= 1'b0;
      flush_src             <= 2'd0;
      flush_req             <= 1'b0;
      trig_in_q             <= 1'b0;
      trig_mark             <= 1'b0;
      beat_ready            <= 1'b0;
      acq_done              <= 1'b0;
      mem_full              <= 1'b0;
      halting               <= 1'b0;
      drop_flush            <= 1'b0;
      trig_armed            <= 1'b0;
    end else begin
      trig_in_q  <= trig_in;
      wr_en      <= 1'b0;
      mem_full   <= 1'b0;
      // Always ready, so a stopped capture never back-pressures the sources.
      beat_ready <= 1'b1; // see RULE4
      // Software writes the counter only while capture is off.
      if (reg_wr && reg_addr == `TCS_OFS_TRGCNT && !capture_enable_bit) begin
        trig_count <= reg_wdata;
      end else if (count_word) begin
        trig_count <= trig_count - 32'h0000_0001; // see RULE11 see RULE22
      end
      if (trig_event) begin
        triggered <= 1'b1;
      end
      // The external trigger arms the countdown; words are counted only after it.
      if (running && trig_in) begin
        trig_armed <= 1'b1;
      end
      // Marks land in the stream only with continuous formatting.
      trig_mark <= contin && ((mark_on_trigger_event && trig_event) ||
                              (mark_on_flush && flush_done) ||
                              (mark_on_trig_in && trig_in_rise)); // see RULE10 see RULE14
      if (|take) begin
        flush_busy <= 1'b1;
        flush_req  <= 1'b1;
        flush_src  <= take[1] ? 2'd1 : (take[2] ? 2'd2 : 2'd0);
        // Flushed trace is not kept when capture ends on that same trigger.
        drop_flush <= halt_on_trigger && take[1]; // see RULE3
      end else if (flush_done) begin
        flush_busy <= 1'b0;
        flush_req  <= 1'b0; // see RULE23
      end
      // The pointer follows each landed word, so post-amble words count like trace.
      if (wr_en) begin
        wr_ptr   <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
        mem_full <= (wr_ptr == {AW{1'b1}}); // see RULE21
      end
      case (state)
        ST_RUN: begin
          // Beats after the stop are still accepted but never stored.
          if (take_beat && !(drop_flush && flush_busy)) begin
            wr_en   <= 1'b1;
            wr_data <= beat_data;
          end
          // The counter path stops on the last counted word, the input path a cycle later.
          if ((!capture_enable_bit && formatter_halted_flag == 1'b0 && halting) ||
              (trig_event && trig_count == 32'h0000_0001 && halt_on_trigger) ||
              (halt_on_trigger && triggered && trig_count == 32'h0000_0000) ||
              (flush_done && halt_on_flush)) begin // see RULE1 see RULE3
            state      <= ST_PAD;
            post_words <= bypass ? 4'd1 : FRAME_WORDS[3:0];
          end
          // Last cycle's enable, so an enable clear is acted on in the first cycle the bit reads low.
          halting <= capture_enable_bit;
        end
        ST_PAD: begin
          // Bypass closes with 0x01 and zero fill; formatted modes add one empty frame.
          wr_en   <= 1'b1; // see RULE12 see RULE13
          wr_data <= bypass ? {24'h00_0000, `TCS_BYP_END_BYTE}
                            : {4{`TCS_PAD_BYTE}}; // see RULE19
          post_words <= post_words - 4'h1;
          if (post_words == 4'h1) begin
            state <= ST_STOP;
          end
        end
        ST_STOP: begin
          formatter_halted_flag <= 1'b1; // see RULE2
          // Only a fresh enable restarts capture; a stop by flush or trigger stays put.
          if (capture_enable_bit && !halting) begin
            state                 <= ST_RUN;
            formatter_halted_flag <= 1'b0;
            triggered             <= 1'b0;
            trig_armed            <= 1'b0;
          end
          halting <= capture_enable_bit;
        end
        default: state <= ST_RUN;
      endcase
      // Done means stopped with no post-trigger words left to store.
      acq_done <= (state == ST_STOP) && (trig_count == 32'h0000_0000); // see RULE20
    end
  end

  // The memory-test port overrides the capture write path inside the memory.
  tcs_trace_ram #(
    .AW (AW)
  ) u_ram (
    .clk       (clk),
    .test_sel  (test_sel),
    .test_addr (test_addr),
    .test_cs   (test_cs),
    .test_we   (test_we),
    .test_din  (test_din),
    .test_dout (test_dout),
    .wr_en     (wr_en),
    .wr_addr   (wr_ptr),
    .wr_data   (wr_data)
  );

endmodule

// >>> tb/tcs_capture_ctrl_assertions.sv
/* Port checker for the capture controller.
   Assumes it is bound to tcs_capture_ctrl and sees its ports only. */
`timescale 1ns/10ps
`include "tcs_regs.vh"
module tcs_capture_ctrl_assertions #(
  parameter AW = 8
) (
  input wire        clk,
  input wire        sys_rst,
  input wire [3:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        beat_ready,
  input wire        flush_req,
  input wire        flush_ack,
  input wire        acq_done,
  input wire        mem_full,
  input wire        trig_mark
);
  reg [`TCS_FF_W-1:0] formatter_flush_control;
  // The mode bits live inside, so a shadow is kept from the writes.
  always @(posedge clk or posedge sys_rst)
    if (sys_rst) formatter_flush_control <= `TCS_FF_RESET;
    else if (reg_wr && reg_addr == `TCS_OFS_FORMATTER_FLUSH_CONTROL) formatter_flush_control <= reg_wdata[`TCS_FF_W-1:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_BEAT_READY: assert property ($past(sys_rst) == 1'b0 |-> beat_ready)
    else $error("beat port stalled");
  AST_FLUSH_HOLD: assert property (flush_req && !flush_ack |=> flush_req)
    else $error("flush request dropped early");
  AST_FLUSH_END: assert property ($fell(flush_req) |-> $past(flush_ack))
    else $error("flush ended without ack");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  AST_UNMAPPED: assert property (reg_rd && reg_addr > `TCS_OFS_WRPTR |=> reg_rdata == 0)
    else $error("unmapped read not zero");
  AST_FORMATTER_FLUSH_CONTROL_TOP: assert property (reg_rd && reg_addr == `TCS_OFS_FORMATTER_FLUSH_CONTROL |=>
    reg_rdata[31:`TCS_FF_W] == 0)
    else $error("control upper bits set");
  AST_FULL_PULSE: assert property (mem_full |=> !mem_full)
    else $error("full event not a pulse");
  AST_MARK_CONT: assert property (trig_mark |-> $past(formatter_flush_control[1:0]) == `TCS_MODE_CONT)
    else $error("mark outside continuous mode");
  COV_FLUSH: cover property ($rose(flush_req));
  COV_DONE: cover property ($rose(acq_done));
  COV_MARK: cover property (trig_mark);
  COV_FULL: cover property (mem_full);
endmodule
bind tcs_capture_ctrl tcs_capture_ctrl_assertions #(.AW(AW)) tcs_capture_ctrl_assertions_inst (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .beat_ready(beat_ready),
  .flush_req(flush_req), .flush_ack(flush_ack), .acq_done(acq_done),
  .mem_full(mem_full), .trig_mark(trig_mark));

// >>> tb/tcs_far_side.sv
/* Trace source model: sends beat bursts and acknowledges flushes.
   Assumes the bench pulses burst_go for one cycle with burst_len set. */
`timescale 1ns/10ps
module tcs_far_side (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        flush_req,
  input  wire        beat_ready,
  input  wire        burst_go,
  input  wire [7:0]  burst_len,
  input  wire [7:0]  ack_wait,
  output reg         flush_ack,
  output wire        beat_valid,
  output wire [31:0] beat_data,
  output wire [1:0]  beat_bytes
);
  reg [7:0] left, seq, waited;
  assign beat_valid = (left != 8'h00);
  // Idle data carries all-ones upper bytes and the inverted count so a stale word is never mistaken for a beat.
  assign beat_data  = beat_valid ? {24'h00_0000, seq} : {24'hFF_FFFF, ~seq};
  assign beat_bytes = 2'b11;
  always @(posedge clk or posedge sys_rst)
    if (sys_rst) begin
      left <= 8'h00;
      seq  <= 8'h00;
    end else if (burst_go) begin
      left <= burst_len;
    end else if (beat_valid && beat_ready) begin
      left <= left - 8'h01;
      seq  <= seq + 8'h01;
    end
  // Ack is held until the request drops.
  always @(posedge clk or posedge sys_rst)
    if (sys_rst) begin
      flush_ack <= 1'b0;
      waited    <= 8'h00;
    end else if (!flush_req) begin
      flush_ack <= 1'b0;
      waited    <= 8'h00;
    end else if (waited == ack_wait) begin
      flush_ack <= 1'b1;
    end else begin
      waited <= waited + 8'h01;
    end
endmodule

// >>> tb/tb_top.sv
/* Bench for the capture controller: register tasks and scenario sequence.
   Assumes tcs_far_side models the trace sources; AW is cut to 4. */
`timescale 1ns/10ps
`include "tcs_regs.vh"
module tb_top;
  reg         clk, sys_rst, reg_wr, reg_rd, trig_in, flush_in, burst_go;
  reg         test_sel, test_cs, test_we, fr_d;
  reg  [3:0]  reg_addr, test_addr;
  reg  [31:0] reg_wdata, test_din, rd;
  reg  [7:0]  burst_len, ack_wait;
  wire        beat_valid, beat_ready, flush_req, flush_ack, acq_done, mem_full, trig_mark;
  wire [31:0] beat_data, reg_rdata, test_dout;
  wire [1:0]  beat_bytes;
  integer     bad_count, checked, flushes, marks, fulls, f0, i, k;
  tcs_capture_ctrl #(.AW(4)) tcs_capture_ctrl_inst (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .beat_valid(beat_valid), .beat_data(beat_data),
    .beat_bytes(beat_bytes), .beat_ready(beat_ready), .flush_req(flush_req),
    .flush_ack(flush_ack), .trig_in(trig_in), .flush_in(flush_in), .acq_done(acq_done),
    .mem_full(mem_full), .trig_mark(trig_mark), .test_sel(test_sel),
    .test_addr(test_addr), .test_cs(test_cs), .test_we(test_we), .test_din(test_din),
    .test_dout(test_dout));
  tcs_far_side tcs_far_side_inst (.clk(clk), .sys_rst(sys_rst), .flush_req(flush_req),
    .beat_ready(beat_ready), .burst_go(burst_go), .burst_len(burst_len),
    .ack_wait(ack_wait), .flush_ack(flush_ack), .beat_valid(beat_valid),
    .beat_data(beat_data), .beat_bytes(beat_bytes));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    fr_d <= flush_req;
    if (flush_req && !fr_d) flushes <= flushes + 1;
    if (trig_mark) marks <= marks + 1;
    if (mem_full) fulls <= fulls + 1;
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task reg_write(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk) reg_wr <= 1'b0;
    end
  endtask
  task reg_read(input [3:0] a);
    begin
      @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk) reg_rd <= 1'b0;
      @(posedge clk) rd = reg_rdata;
    end
  endtask
  task ram_access(input we, input [3:0] a, input [31:0] d);
    begin
      @(posedge clk) {test_cs, test_we, test_addr, test_din} <= {1'b1, we, a, d};
      @(posedge clk) test_cs <= 1'b0;
      @(posedge clk) rd = test_dout;
    end
  endtask
  task burst(input [7:0] n);
    begin
      @(posedge clk) {burst_go, burst_len} <= {1'b1, n};
      @(posedge clk) burst_go <= 1'b0;
      repeat (n + 8) @(posedge clk);
    end
  endtask
  task do_reset;
    begin
      sys_rst <= 1'b1;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    #200000;
    bad_count = bad_count + 1;
    give_verdict;
  end
  initial begin
    {reg_wr, reg_rd, trig_in, flush_in, burst_go, test_sel, test_cs, test_we} = 0;
    {reg_addr, test_addr, reg_wdata, test_din, burst_len} = 0;
    {bad_count, checked, flushes, marks, fulls} = 0;
    ack_wait = 8'd6;
    sys_rst = 1'b1;
    do_reset;
    reg_read(4'h9);
    check(rd, 32'h0000_0000);
    // Capture is enabled but cannot run while the test port owns the memory; its word must survive.
    test_sel <= 1'b1;
    ram_access(1'b1, 4'h0, 32'hA5C3_0F96);
    reg_write(`TCS_OFS_CTRL, 32'h0000_0001);
    burst(8'd3);
    ram_access(1'b0, 4'h0, 32'h0000_0000);
    check(rd, 32'hA5C3_0F96);
    test_sel <= 1'b0;
    reg_write(`TCS_OFS_FORMATTER_FLUSH_CONTROL, 32'h0000_0010);
    f0 = flushes;
    flush_in <= 1'b1;
    for (i = 0; i < 50 && !flush_req; i = i + 1) @(posedge clk);
    flush_in <= 1'b0;
    @(posedge clk) flush_in <= 1'b1;
    reg_write(`TCS_OFS_FORMATTER_FLUSH_CONTROL, 32'h0000_0050);
    for (i = 0; i < 200 && flushes < f0 + 2; i = i + 1) @(posedge clk);
    repeat (40) @(posedge clk);
    check(flushes - f0, 2);
    reg_read(`TCS_OFS_STATUS);
    check(rd[`TCS_ST_HALTED], 1'b0);
    flush_in <= 1'b0;
    reg_write(`TCS_OFS_FORMATTER_FLUSH_CONTROL, 32'h0000_1040);
    for (i = 0; i < 200 && (flushes < f0 + 3 || flush_req); i = i + 1) @(posedge clk);
    repeat (10) @(posedge clk);
    reg_read(`TCS_OFS_STATUS);
    check(rd[`TCS_ST_HALTED], 1'b1);
    reg_read(`TCS_OFS_WRPTR);
    f0 = rd;
    burst(8'd5);
    reg_read(`TCS_OFS_WRPTR);
    check(rd, f0);
    do_reset;
    reg_write(`TCS_OFS_TRGCNT, 32'h0000_0000);
    reg_write(`TCS_OFS_CTRL, 32'h0000_0001);
    burst(8'd20);
    check(fulls != 0, 1'b1);
    reg_write(`TCS_OFS_CTRL, 32'h0000_0000);
    repeat (10) @(posedge clk);
    reg_read(`TCS_OFS_STATUS);
    check(rd[`TCS_ST_HALTED], 1'b1);
    check(acq_done, 1'b1);
    reg_read(`TCS_OFS_WRPTR);
    check(rd, 32'h0000_0005);
    test_sel <= 1'b1;
    ram_access(1'b0, 4'h4, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    test_sel <= 1'b0;
    // Three counted words after the trigger, then the bypass end word.
    do_reset;
    reg_write(`TCS_OFS_TRGCNT, 32'h0000_0003);
    reg_write(`TCS_OFS_FORMATTER_FLUSH_CONTROL, 32'h0000_2000);
    reg_write(`TCS_OFS_CTRL, 32'h0000_0001);
    trig_in <= 1'b1;
    @(posedge clk) trig_in <= 1'b0;
    burst(8'd8);
    reg_read(`TCS_OFS_WRPTR);
    check(rd, 32'h0000_0004);
    check(acq_done, 1'b1);
    // Same trigger in continuous, normal and bypass mode; only the first marks.
    for (k = 0; k < 3; k = k + 1) begin
      do_reset;
      reg_write(`TCS_OFS_FORMATTER_FLUSH_CONTROL, 32'h0000_2220 | (k == 0 ? 3 : (k == 1 ? 1 : 0)));
      reg_write(`TCS_OFS_CTRL, 32'h0000_0001);
      reg_write(`TCS_OFS_TRGCNT, 32'h0000_0009);
      reg_read(`TCS_OFS_TRGCNT);
      check(rd, 32'h0000_0000);
      f0 = flushes;
      i = marks;
      trig_in <= 1'b1;
      @(posedge clk) trig_in <= 1'b0;
      for (f0 = f0; f0 + 1 > flushes || !acq_done; f0 = f0) @(posedge clk);
      check(acq_done, 1'b1);
      check(marks != i, k == 0);
      reg_read(`TCS_OFS_STATUS);
      check(rd[`TCS_ST_TRIGGERED], 1'b1);
      reg_read(`TCS_OFS_WRPTR);
      check(rd, k == 2 ? 1 : `TCS_FRAME_WORDS);
    end
    give_verdict;
  end
endmodule
